//--- rtl/dccmp_down_counter.sv
// One down-counter of the clock comparator, stepped by rising edges of a
// selected source level.
// Assumes the source level is synchronous to clock and slower than half
// its rate, so that every rising edge is seen.
`timescale 1ns/1ps
`include "dccmp_map.svh"

module dccmp_down_counter (
   input wire logic clock,
   input wire logic nrst,
   input wire logic srcLevel,
   input wire logic load,
   input wire logic run,
   input wire logic [`DCCMP_CNT_W-1:0] seed,
   output logic [`DCCMP_CNT_W-1:0] count,
   output logic tick,
   output logic expired
);
   import dccmp_pkg::*;

   logic srcPrev_q;
   logic [`DCCMP_CNT_W-1:0] count_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         srcPrev_q <= 1'b0;
      end else begin
         srcPrev_q <= srcLevel;
      end
   end

   assign expired = (count_q == '0);
   assign tick = srcLevel & ~srcPrev_q & run & ~expired;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= seed;
      end else if (tick) begin
         count_q <= count_q - `DCCMP_CNT_W'(1);
      end
   end

   assign count = count_q;

endmodule

//--- rtl/dccmp_map.svh
// Register offsets, field positions, reset values and source codes of the
// clock comparator.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DCCMP_MAP_SVH
`define DCCMP_MAP_SVH

`define DCCMP_SEED_W 20
`define DCCMP_CNT_W 21
`define DCCMP_DEC_W 8

`define DCCMP_OFF_CTRL 8'h00
`define DCCMP_OFF_SEED0 8'h04
`define DCCMP_OFF_VALID0 8'h08
`define DCCMP_OFF_SEED1 8'h0c
`define DCCMP_OFF_CLKSEL 8'h10
`define DCCMP_OFF_STATUS 8'h14
`define DCCMP_OFF_COUNT0 8'h18
`define DCCMP_OFF_COUNT1 8'h1c

`define DCCMP_CTRL_START 0
`define DCCMP_STAT_ERR 0
`define DCCMP_STAT_DONE 1
`define DCCMP_STAT_BUSY 2
`define DCCMP_SEL_SRC0_LSB 0
`define DCCMP_SEL_KEY1_LSB 8
`define DCCMP_SEL_SRC1_LSB 12

`define DCCMP_RST_SEED 20'h00000
`define DCCMP_RST_CODE 4'h0

`define DCCMP_SRC0_HFLPO 4'h5
`define DCCMP_SRC0_TEST 4'ha
`define DCCMP_KEY_OPEN 4'ha
`define DCCMP_SRC1_PLL 4'h0
`define DCCMP_SRC1_NONE_A 4'h1
`define DCCMP_SRC1_LFLPO 4'h2
`define DCCMP_SRC1_HFLPO 4'h3
`define DCCMP_SRC1_PUMP 4'h4
`define DCCMP_SRC1_EXT 4'h5
`define DCCMP_SRC1_NONE_B 4'h6
`define DCCMP_SRC1_RING 4'h7

`endif

//--- rtl/dccmp_pkg.sv
// Types shared by the clock comparator design files.
// Assumes the constant header is on the include path.
`include "dccmp_map.svh"

package dccmp_pkg;

   typedef struct packed {
      logic mainOscillatorInput;
      logic hfLowPowerOscillator;
      logic lfLowPowerOscillator;
      logic testClock;
      logic peripheralClock;
      logic systemBusClock;
      logic timerChannelInput;
      logic pllFreeRunClock;
      logic flashPumpOscillator;
      logic externalClockInput;
      logic ringOscillator;
   } dccmp_clk_src_type;

   typedef struct packed {
      logic [3:0] src1;
      logic [3:0] key1;
      logic [3:0] src0;
   } dccmp_sel_type;

   typedef enum logic {
      StIdle,
      StRun
   } dccmp_state_type;

endpackage

//--- rtl/dccmp_top.sv
// Dual clock comparator with an AHB-Lite register slave.
// Assumes all clock source levels are synchronous inputs sampled by clock,
// and a single AHB-Lite master issuing whole-word single transfers.
`timescale 1ns/1ps
`include "dccmp_map.svh"

// Behaviour
// (R1) Counter 0 counts reference clock edges and counter 1 counts edges of the clock under test.
// (R2) Software loads each counter with its own seed before starting a comparison.
// (R3) A start loads both counters at once and both then count down together.
// (R4) A frequency mismatch raises the error output that goes to the interrupt logic.
// (R5) In normal mode counter 0 takes the fast low-power oscillator for 0x5, the test clock for 0xA, else the main oscillator; in test mode the peripheral clock.
// (R6) Counter 1 takes the timer channel input unless the key is 0xA, and the system bus clock in test mode.
// (R7) With key 0xA counter 1 selects PLL, slow LOW_POWER_OSCILLATOR, fast LOW_POWER_OSCILLATOR, pump, external, ring or peripheral clock by code.
// (R8) Counter 1 codes 0x1 and 0x6 under key 0xA carry no clock.
// (R9) An error is flagged when counter 1 expires before the reference window opens or is still running when counter 0 expires.
module dccmp_top (
   input wire logic clock,
   input wire logic nrst,
   input wire logic testMode,
   input wire dccmp_pkg::dccmp_clk_src_type clkSrc,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic errorOut,
   output logic busy
);
   import dccmp_pkg::*;

   dccmp_state_type state_q;
   dccmp_sel_type sel_q;
   logic [`DCCMP_SEED_W-1:0] seed0_q, valid0_q, seed1_q;
   logic err_q, done_q;
   logic phase_q, wr_q, rdReady_q;
   logic [`DCCMP_DEC_W-1:0] addr_q;
   logic accept, wrNow, startReq, loadPulse, running;
   logic refLevel, cutLevel, tick0, tick1, exp0, exp1;
   logic errSet, doneSet, errClr, doneClr;
   logic [`DCCMP_CNT_W-1:0] seedTotal, cnt0, cnt1, validExt;

   function automatic logic pickRef(input logic tm, input logic [3:0] src,
                                    input dccmp_clk_src_type c);
      if (tm) begin
         pickRef = c.peripheralClock;
      end else if (src == `DCCMP_SRC0_HFLPO) begin
         pickRef = c.hfLowPowerOscillator;
      end else if (src == `DCCMP_SRC0_TEST) begin
         pickRef = c.testClock;
      end else begin
         pickRef = c.mainOscillatorInput;
      end
   endfunction

   function automatic logic pickCut(input logic tm, input dccmp_sel_type s,
                                    input dccmp_clk_src_type c);
      pickCut = 1'b0;
      if (tm) begin
         pickCut = c.systemBusClock;
      end else if (s.key1 != `DCCMP_KEY_OPEN) begin
         pickCut = c.timerChannelInput;
      end else if (s.src1[3]) begin
         pickCut = c.peripheralClock;
      end else begin
         // (R7) keyed source codes
         case (s.src1)
            `DCCMP_SRC1_PLL: pickCut = c.pllFreeRunClock;
            `DCCMP_SRC1_LFLPO: pickCut = c.lfLowPowerOscillator;
            `DCCMP_SRC1_HFLPO: pickCut = c.hfLowPowerOscillator;
            `DCCMP_SRC1_PUMP: pickCut = c.flashPumpOscillator;
            `DCCMP_SRC1_EXT: pickCut = c.externalClockInput;
            `DCCMP_SRC1_RING: pickCut = c.ringOscillator;
            // (R8) unassigned codes stay dead
            default: pickCut = 1'b0;
         endcase
      end
   endfunction

   // Bus slave: writes land in the data phase, reads take one wait state so
   // that read data always comes from a flip-flop and sees earlier writes.
   assign accept = hsel & htrans[1] & hready;
   assign wrNow = phase_q & wr_q;
   assign hreadyout = ~(phase_q & ~wr_q & ~rdReady_q);
   assign hresp = 1'b0;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         phase_q <= 1'b0;
         wr_q <= 1'b0;
         rdReady_q <= 1'b0;
         addr_q <= '0;
      end else begin
         if (hready) begin
            phase_q <= accept;
            rdReady_q <= 1'b0;
         end else if (phase_q & ~wr_q) begin
            rdReady_q <= 1'b1;
         end
         if (accept) begin
            wr_q <= hwrite;
            addr_q <= haddr[`DCCMP_DEC_W-1:0];
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hrdata <= '0;
      end else if (phase_q & ~wr_q & ~rdReady_q) begin
         case (addr_q)
            `DCCMP_OFF_SEED0: hrdata <= 32'(seed0_q);
            `DCCMP_OFF_VALID0: hrdata <= 32'(valid0_q);
            `DCCMP_OFF_SEED1: hrdata <= 32'(seed1_q);
            `DCCMP_OFF_CLKSEL: hrdata <= 32'({sel_q.src1, sel_q.key1,
                                              4'h0, sel_q.src0});
            `DCCMP_OFF_STATUS: hrdata <= 32'({running, done_q, err_q});
            `DCCMP_OFF_COUNT0: hrdata <= 32'(cnt0);
            `DCCMP_OFF_COUNT1: hrdata <= 32'(cnt1);
            default: hrdata <= '0;
         endcase
      end
   end

   // (R2) seed and clock select registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         seed0_q <= `DCCMP_RST_SEED;
         valid0_q <= `DCCMP_RST_SEED;
         seed1_q <= `DCCMP_RST_SEED;
         sel_q <= '{`DCCMP_RST_CODE, `DCCMP_RST_CODE, `DCCMP_RST_CODE};
      end else if (wrNow) begin
         case (addr_q)
            `DCCMP_OFF_SEED0: seed0_q <= hwdata[`DCCMP_SEED_W-1:0];
            `DCCMP_OFF_VALID0: valid0_q <= hwdata[`DCCMP_SEED_W-1:0];
            `DCCMP_OFF_SEED1: seed1_q <= hwdata[`DCCMP_SEED_W-1:0];
            `DCCMP_OFF_CLKSEL: begin
               sel_q.src0 <= hwdata[`DCCMP_SEL_SRC0_LSB +: 4];
               sel_q.key1 <= hwdata[`DCCMP_SEL_KEY1_LSB +: 4];
               sel_q.src1 <= hwdata[`DCCMP_SEL_SRC1_LSB +: 4];
            end
            default: begin
            end
         endcase
      end
   end

   assign startReq = wrNow & (addr_q == `DCCMP_OFF_CTRL) &
                     hwdata[`DCCMP_CTRL_START];
   assign errClr = wrNow & (addr_q == `DCCMP_OFF_STATUS) &
                   hwdata[`DCCMP_STAT_ERR];
   assign doneClr = wrNow & (addr_q == `DCCMP_OFF_STATUS) &
                    hwdata[`DCCMP_STAT_DONE];

   // (R3) common start
   assign loadPulse = (state_q == StIdle) & startReq;
   assign running = (state_q == StRun);
   assign busy = running;
   assign validExt = {1'b0, valid0_q};
   assign seedTotal = {1'b0, seed0_q} + validExt;

   // (R5) reference selection
   assign refLevel = pickRef(testMode, sel_q.src0, clkSrc);
   // (R6) clock under test selection
   assign cutLevel = pickCut(testMode, sel_q, clkSrc);

   // (R1) reference counter
   dccmp_down_counter u_count0 (
      .clock(clock),
      .nrst(nrst),
      .srcLevel(refLevel),
      .load(loadPulse),
      .run(running),
      .seed(seedTotal),
      .count(cnt0),
      .tick(tick0),
      .expired(exp0)
   );

   // (R1) counter under test
   dccmp_down_counter u_count1 (
      .clock(clock),
      .nrst(nrst),
      .srcLevel(cutLevel),
      .load(loadPulse),
      .run(running),
      .seed({1'b0, seed1_q}),
      .count(cnt1),
      .tick(tick1),
      .expired(exp1)
   );

   // (R9) window check
   assign errSet = running & ((exp1 & (cnt0 > validExt)) | (exp0 & ~exp1));
   assign doneSet = running & (exp0 | exp1);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= StIdle;
      end else begin
         case (state_q)
            StIdle: if (startReq) state_q <= StRun;
            StRun: if (doneSet) state_q <= StIdle;
            default: state_q <= StIdle;
         endcase
      end
   end

   // (R4) sticky error, set beats clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         err_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         err_q <= errSet | (err_q & ~errClr);
         done_q <= doneSet | (done_q & ~doneClr);
      end
   end

   assign errorOut = err_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence startSeq;
      loadPulse ##1 running;
   endsequence

   ref_counts_down_a: assert property ( // (R1)
      running && tick0 |=> cnt0 == $past(cnt0) - `DCCMP_CNT_W'(1))
      else $error("Reference counter did not step on its edge.");
   seed_loaded_a: assert property ( // (R2)
      startSeq |-> cnt1 == {1'b0, seed1_q} && cnt0 == $past(seedTotal))
      else $error("Seeds were not loaded at start.");
   both_start_a: assert property ( // (R3)
      $rose(running) |-> $past(loadPulse) && cnt0 == $past(seedTotal) &&
                         cnt1 == {1'b0, $past(seed1_q)})
      else $error("Comparison started without a common load.");
   early_error_a: assert property ( // (R4)
      running && exp1 && cnt0 > validExt |=> errorOut && !running)
      else $error("Early expiry did not raise the error.");
   ref_select_a: assert property ( // (R5)
      !testMode && sel_q.src0 == `DCCMP_SRC0_HFLPO
      |-> refLevel == clkSrc.hfLowPowerOscillator)
      else $error("Wrong reference source.");
   test_select_a: assert property ( // (R6)
      testMode |-> cutLevel == clkSrc.systemBusClock &&
                   refLevel == clkSrc.peripheralClock)
      else $error("Test mode sources not taken.");
   pll_select_a: assert property ( // (R7)
      !testMode && sel_q.key1 == `DCCMP_KEY_OPEN &&
      sel_q.src1 == `DCCMP_SRC1_PLL |-> cutLevel == clkSrc.pllFreeRunClock)
      else $error("Wrong clock under test source.");
   empty_code_a: assert property ( // (R8)
      !testMode && sel_q.key1 == `DCCMP_KEY_OPEN &&
      (sel_q.src1 == `DCCMP_SRC1_NONE_A || sel_q.src1 == `DCCMP_SRC1_NONE_B)
      |-> !cutLevel && !tick1)
      else $error("Unassigned code carried a clock.");
   late_error_a: assert property ( // (R9)
      running && exp0 && !exp1 |=> errorOut ##1 (errorOut || $past(errClr)))
      else $error("Late expiry did not raise a lasting error.");

endmodule

//--- verification/dccmp_src_model.sv
// Behavioural model of the clock sources that feed the comparator.
// Assumes every source is a level that the system clock samples.
`timescale 1ns/1ps

module dccmp_src_model (
   input wire logic clock,
   input wire logic nrst,
   output dccmp_pkg::dccmp_clk_src_type clkSrc
);
   import dccmp_pkg::*;

   logic [10:0] level_q;
   logic [3:0] phase_q [11];

   // independent source clocks
   // Source bit b holds each level for b+1 cycles, so every rate differs.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         level_q <= 11'h000;
         for (int b = 0; b < 11; b++) begin
            phase_q[b] <= 4'h0;
         end
      end else begin
         for (int b = 0; b < 11; b++) begin
            if (phase_q[b] == 4'(b)) begin
               phase_q[b] <= 4'h0;
               level_q[b] <= ~level_q[b];
            end else begin
               phase_q[b] <= phase_q[b] + 4'h1;
            end
         end
      end
   end

   assign clkSrc = dccmp_clk_src_type'(level_q);
endmodule

//--- verification/tb.sv
// Self-checking bench for the clock comparator with its source model.
// Assumes the package, the header and the design files are compiled first.
`timescale 1ns/1ps
`include "dccmp_map.svh"

module tb;
   import dccmp_pkg::*;

   logic clock, nrst, testMode, hsel, hwrite;
   logic [31:0] haddr, hwdata, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hreadyout, hresp, errorOut, busy;
   wire logic [31:0] hrdata;
   wire dccmp_clk_src_type clkSrc;
   int miscompares = 0;
   int cmp_count = 0;
   // Digits: outcome (0 pass unless src1 is an unassigned code, 1 early, 2 late), test mode, src0, key, src1.
   localparam logic [19:0] cases [13] = '{20'h005a0, 20'h00aa2, 20'h003a3,
      20'h00ca4, 20'h005a5, 20'h00aa7, 20'h007af, 20'h00530, 20'h01000,
      20'h005a1, 20'h005a6, 20'h105a3, 20'h205a3};

   dccmp_src_model dccmp_src_model_inst (.clock(clock), .nrst(nrst),
      .clkSrc(clkSrc));
   dccmp_top dccmp_top_inst (.clock(clock), .nrst(nrst),
      .testMode(testMode), .clkSrc(clkSrc), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .errorOut(errorOut), .busy(busy));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Ready is judged at the falling edge, where it has settled.
   task automatic waitReady();
      int n;
      n = 0;
      do @(negedge clock); while (hreadyout !== 1'b1 && ++n < 50);
      if (n >= 50) miscompares++;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      waitReady();
      @(posedge clock);
      htrans <= 2'b00;
      hwdata <= wd;
      waitReady();
      check(32'(hresp), 32'h0);
      rd = hrdata;
      @(posedge clock);
   endtask

   function automatic int srcIdx0(logic tm, logic [3:0] s);
      if (tm) return 6;
      return s == `DCCMP_SRC0_HFLPO ? 9 : s == `DCCMP_SRC0_TEST ? 7 : 10;
   endfunction

   function automatic int srcIdx1(logic tm, logic [3:0] k, logic [3:0] s);
      if (tm) return 5;
      if (k != `DCCMP_KEY_OPEN) return 4;
      case (s)
         4'h0: return 3;
         4'h2: return 8;
         4'h3: return 9;
         4'h4: return 2;
         4'h5: return 1;
         4'h7: return 0;
         4'h1, 4'h6: return -1;
         default: return 6;
      endcase
   endfunction

   task automatic compare(input logic [19:0] c);
      int i0, i1, h1, s1, e0, m, s0, v0, n;
      logic expErr;
      i0 = srcIdx0(c[12], c[11:8]);
      i1 = srcIdx1(c[12], c[7:4], c[3:0]);
      h1 = (i1 < 0) ? 1 : i1 + 1;
      s1 = 100 + $urandom % 32;
      e0 = s1 * h1 / (i0 + 1);
      m = e0 / 32 + 2;
      s0 = c[19:16] == 1 ? 2 * e0 + 10 : c[19:16] == 2 ? e0 / 2 : e0 - m;
      v0 = c[19:16] == 0 ? 2 * m : c[19:16] == 1 ? 2 : 1;
      expErr = (c[19:16] != 0) || (i1 < 0);
      testMode <= c[12];
      bus(1'b1, `DCCMP_OFF_SEED0, s0, d);
      bus(1'b1, `DCCMP_OFF_VALID0, v0, d);
      bus(1'b1, `DCCMP_OFF_SEED1, s1, d);
      bus(1'b1, `DCCMP_OFF_CLKSEL, {16'h0, c[3:0], c[7:4], 4'h0, c[11:8]}, d);
      bus(1'b0, `DCCMP_OFF_CLKSEL, 0, d);
      check(d, {16'h0, c[3:0], c[7:4], 4'h0, c[11:8]});
      bus(1'b1, `DCCMP_OFF_CTRL, 32'h1, d);
      @(negedge clock);
      check(32'(busy), 32'h1);
      @(posedge clock);
      n = 0;
      do bus(1'b0, `DCCMP_OFF_STATUS, 0, d);
      while (d[1] !== 1'b1 && ++n < 2000);
      check(32'(errorOut), 32'(expErr));
      check(d & 32'h7, {29'h0, 2'b01, expErr});
      bus(1'b0, `DCCMP_OFF_COUNT1, 0, d);
      check(32'(d == 0), 32'(c[19:16] != 2 && i1 >= 0));
      bus(1'b1, `DCCMP_OFF_STATUS, 32'h3, d);
      @(negedge clock);
      check(32'(errorOut), 32'h0);
      @(posedge clock);
      bus(1'b0, `DCCMP_OFF_STATUS, 0, d);
      check(d & 32'h7, 32'h0);
      $display("test %h ended", c);
   endtask

   initial begin
      logic [31:0] v;
      nrst = 1'b0;
      testMode = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      v = $urandom(32'h1db8);
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      bus(1'b0, `DCCMP_OFF_SEED1, 0, d);
      check(d, 32'h0);
      bus(1'b0, 8'h40, 0, d);
      check(d, 32'h0);
      v = $urandom & 32'hfffff;
      bus(1'b1, `DCCMP_OFF_SEED0, v, d);
      bus(1'b0, `DCCMP_OFF_SEED0, 0, d);
      check(d, v);
      $display("test registers ended");
      foreach (cases[i]) compare(cases[i]);
      for (int i = 0; i < 4; i++) begin
         compare({8'h00, 4'($urandom), `DCCMP_KEY_OPEN, 4'($urandom)});
      end
      end_of_test();
   end

   initial begin
      #(95000 * 10);
      miscompares++;
      end_of_test();
   end
endmodule
